// ==== hdl/pti_pkg.sv ====
// constants shared by the interval timer, status and serial link logic
package pti_pkg;
  // command address codes carried in the first byte of a frame
  localparam logic [7:0] CMD_GEN_RESET = 8'h01;
  localparam logic [7:0] CMD_CTRL_WR = 8'h30;
  localparam logic [7:0] CMD_READ_STATUS = 8'h31;
  localparam logic [7:0] CMD_NOTONE_WR = 8'h33;
  localparam logic [7:0] CMD_TONE1_WR = 8'h34;
  localparam logic [7:0] CMD_TONE2_WR = 8'h35;
  localparam logic [7:0] CMD_TIMER_WR = 8'h36;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] NOTONE_RESET = 8'h00;
  localparam logic [15:0] TONE_RESET = 16'h0000;
  // control register fields
  localparam int CTRL_MID_BAND_BIT = 0;
  localparam int CTRL_DEC_IRQ_EN_BIT = 5;
  localparam int CTRL_TMR_IRQ_EN_BIT = 6;
  // status register fields
  localparam int STAT_MEAS_BIT = 0;
  localparam int STAT_NOTONE_BIT = 1;
  localparam int STAT_TIMER_BIT = 2;
  localparam int STAT_FLAGS = 3;
  // timer period code field of the timer data byte
  localparam int TMR_CODE_W = 4;
  // time base per period step, in milliseconds
  localparam int STEP_HIGH_MS = 10;
  localparam int STEP_MID_MS = 20;
  // system clock rate and derived step lengths in cycles
  localparam int CLK_HZ = 200_000_000;
  localparam int STEP_HIGH_CYC = STEP_HIGH_MS * (CLK_HZ / 1000);
  localparam int STEP_MID_CYC = STEP_MID_MS * (CLK_HZ / 1000);
endpackage : pti_pkg

// ==== hdl/pti_serial_link.sv ====
// serial command receiver and status reply shifter on the bus clock
`timescale 1ns/1ps
`default_nettype none
module pti_serial_link (
  // bus side
  input wire logic sclk,
  input wire logic csn,
  input wire logic cmd_data,
  output logic reply_data_o,
  output logic reply_data_oe_n,
  // system reset
  input wire logic resetn,
  // towards the system clock domain
  input wire logic [7:0] reply_byte,
  output logic [7:0] byte_reg,
  output logic byte_first_reg,
  output logic byte_tgl_reg
);
  // frame state is cleared whenever chip select is high
  logic frame_rst_n;
  logic [2:0] bit_cnt_reg; // bit position within the current byte
  logic [6:0] shift_reg; // first seven bits of the byte, msb first
  logic first_reg; // next completed byte is the frame's address byte
  logic reply_reg; // current byte is a status reply
  logic [7:0] rx_byte;

  assign frame_rst_n = resetn & ~csn;
  assign rx_byte = {shift_reg, cmd_data};

  // bit counting and msb first shifting, sampled on the rising edge
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= rx_byte[6:0];
    end
  end

  // byte position within the frame and reply phase tracking
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      first_reg <= 1'b1;
      reply_reg <= 1'b0;
    end else if (bit_cnt_reg == 3'h7) begin
      first_reg <= 1'b0;
      // a read status address turns the next byte into a reply
      reply_reg <= first_reg && (rx_byte == pti_pkg::CMD_READ_STATUS);
    end
  end

  // completed byte handed over with a toggle; data stays stable for
  // at least eight bus clocks, far longer than the synchroniser needs
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      byte_reg <= 8'h00;
      byte_first_reg <= 1'b0;
      byte_tgl_reg <= 1'b0;
    end else if (!csn && bit_cnt_reg == 3'h7 && !reply_reg) begin
      byte_reg <= rx_byte;
      byte_first_reg <= first_reg;
      byte_tgl_reg <= ~byte_tgl_reg;
    end
  end

  // reply bits msb first; the snapshot is settled long before the
  // first reply edge because of the gap required between bytes
  assign reply_data_o = reply_reg ? reply_byte[~bit_cnt_reg] : 1'b0;
  assign reply_data_oe_n = ~reply_reg;
endmodule : pti_serial_link
`default_nettype wire

// ==== hdl/pti_periodic_timer.sv ====
// interval timer, event status flags, interrupt and powersave control
//
// Notes on behaviour
// - address 36 hex plus one period byte
// - period is code times 10 or 20 ms
// - period byte load restarts the timer countdown
// - expiry sets status bit 2, may interrupt
// - expired flag cleared by read, write, reset
// - timer reloads and repeats after each expiry
// - flag and interrupt hold until cleared
// - general reset 01 clears all listed registers
// - tone absent interrupts only with control bit 5
// - timer interrupts only with control bit 6
// - measurement done sets bit 0, interrupts on bit 5
// - status read drops interrupt, replies, clears flags
// - summing amp saves when both encoders save
// - clock and bus logic never power saved
// - after reset: high band, no interrupts, timers zero
// - measurement interrupts repeat until tone absent reported
// - bytes travel most significant bit first
// - each byte acts when its last bit arrives
`timescale 1ns/1ps
`default_nettype none
module pti_periodic_timer #(
  parameter int STEP_HIGH_CYC = pti_pkg::STEP_HIGH_CYC,
  parameter int STEP_MID_CYC = pti_pkg::STEP_MID_CYC,
  parameter int PRE_W = 22
) (
  // system clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial control bus
  input wire logic sclk,
  input wire logic csn,
  input wire logic cmd_data,
  output logic reply_data_o,
  output logic reply_data_oe_n,
  output logic irq_n,
  // decoder event hooks, one cycle pulses on clk
  input wire logic meas_done,
  input wire logic notone_expired,
  // register contents for the tone and decoder sections
  output logic [7:0] ctrl_reg,
  output logic [7:0] notone_period_reg,
  output logic [15:0] tone1_reg,
  output logic [15:0] tone2_reg,
  // powersave controls
  output logic enc1_save,
  output logic enc2_save,
  output logic sum_amp_save
);
  // refuse step lengths the prescaler cannot count
  if (STEP_HIGH_CYC < 1 || STEP_MID_CYC < 1 ||
      STEP_HIGH_CYC >= 2 ** PRE_W || STEP_MID_CYC >= 2 ** PRE_W) begin : g_bad
    $error("step cycle counts do not fit the prescaler width");
  end

  // parser states: waiting for an address byte or for data bytes
  typedef enum logic {
    PS_ADDR,
    PS_DATA
  } pti_parse_t;

  // handover from the bus clock domain
  logic [7:0] link_byte; // last completed byte, stable between toggles
  logic link_first; // byte was the first of its frame
  logic link_tgl; // flips once per completed byte that is not a status reply
  logic tgl_s1_reg; // first synchroniser stage, read only by the second
  logic tgl_s2_reg;
  logic tgl_s3_reg; // previous synchronised value for edge detection
  logic new_byte; // one cycle pulse per handed over byte in the clk domain

  // command parser
  pti_parse_t state_reg;
  logic [7:0] addr_reg; // address of the command in progress
  logic [7:0] hi_byte_reg; // first data byte of a two byte write
  logic need_two_reg; // a two byte command still expects its first byte

  // decoded command strobes
  logic gen_reset; // general reset command
  logic stat_read; // read status command
  logic wr_ctrl;
  logic wr_notone;
  logic wr_tone1;
  logic wr_tone2;
  logic wr_timer;

  // interval timer
  logic [pti_pkg::TMR_CODE_W-1:0] code_reg; // active period code
  logic [pti_pkg::TMR_CODE_W-1:0] left_reg; // steps left in this period
  logic [PRE_W-1:0] pre_cnt_reg; // cycles within the current step
  logic [PRE_W-1:0] step_last; // last prescaler count for the band
  logic step_end;
  logic expire; // one cycle pulse at the end of each period

  // status flags and interrupt
  logic [pti_pkg::STAT_FLAGS-1:0] flag_reg;
  logic [pti_pkg::STAT_FLAGS-1:0] flag_next;
  logic [pti_pkg::STAT_FLAGS-1:0] flag_set;
  logic [pti_pkg::STAT_FLAGS-1:0] flag_clr;
  logic [pti_pkg::STAT_FLAGS-1:0] irq_en;
  logic [7:0] ctrl_next;
  logic [7:0] stat_snap_reg; // status byte shifted out on the reply line

  // bus front end runs on the bus clock; it has no powersave gating
  pti_serial_link u_link (
    .sclk(sclk),
    .csn(csn),
    .cmd_data(cmd_data),
    .reply_data_o(reply_data_o),
    .reply_data_oe_n(reply_data_oe_n),
    .resetn(resetn),
    .reply_byte(stat_snap_reg),
    .byte_reg(link_byte),
    .byte_first_reg(link_first),
    .byte_tgl_reg(link_tgl)
  );

  // two flops on the toggle, a third only for the edge detector
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= link_tgl;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign new_byte = tgl_s2_reg ^ tgl_s3_reg;

  // frame parser; the first byte of any frame is always an address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= PS_ADDR;
      addr_reg <= 8'h00;
      hi_byte_reg <= 8'h00;
      need_two_reg <= 1'b0;
    end else if (new_byte) begin
      if (link_first) begin
        addr_reg <= link_byte;
        unique case (link_byte)
          pti_pkg::CMD_TIMER_WR, pti_pkg::CMD_CTRL_WR,
          pti_pkg::CMD_NOTONE_WR: begin
            state_reg <= PS_DATA;
            need_two_reg <= 1'b0;
          end
          pti_pkg::CMD_TONE1_WR, pti_pkg::CMD_TONE2_WR: begin
            state_reg <= PS_DATA;
            need_two_reg <= 1'b1;
          end
          default: begin
            // unknown, reset and status read take no data bytes
            state_reg <= PS_ADDR;
            need_two_reg <= 1'b0;
          end
        endcase
      end else if (state_reg == PS_DATA) begin
        if (need_two_reg) begin
          hi_byte_reg <= link_byte; // upper tone byte arrives first
          need_two_reg <= 1'b0;
        end else begin
          state_reg <= PS_ADDR; // extra bytes are ignored
        end
      end
    end
  end

  // strobes fire in the cycle the last byte of a command arrives
  always_comb begin
    gen_reset = 1'b0;
    stat_read = 1'b0;
    wr_ctrl = 1'b0;
    wr_notone = 1'b0;
    wr_tone1 = 1'b0;
    wr_tone2 = 1'b0;
    wr_timer = 1'b0;
    if (new_byte && link_first) begin
      gen_reset = (link_byte == pti_pkg::CMD_GEN_RESET);
      stat_read = (link_byte == pti_pkg::CMD_READ_STATUS);
    end else if (new_byte && state_reg == PS_DATA && !need_two_reg) begin
      wr_ctrl = (addr_reg == pti_pkg::CMD_CTRL_WR);
      wr_notone = (addr_reg == pti_pkg::CMD_NOTONE_WR);
      wr_tone1 = (addr_reg == pti_pkg::CMD_TONE1_WR);
      wr_tone2 = (addr_reg == pti_pkg::CMD_TONE2_WR);
      wr_timer = (addr_reg == pti_pkg::CMD_TIMER_WR);
    end
  end

  // control register; general reset leaves high band, no interrupts
  assign ctrl_next = gen_reset ? pti_pkg::CTRL_RESET :
                     wr_ctrl ? link_byte : ctrl_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= pti_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // decoder and tone generator registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      notone_period_reg <= pti_pkg::NOTONE_RESET;
      tone1_reg <= pti_pkg::TONE_RESET;
      tone2_reg <= pti_pkg::TONE_RESET;
    end else if (gen_reset) begin
      notone_period_reg <= pti_pkg::NOTONE_RESET;
      tone1_reg <= pti_pkg::TONE_RESET;
      tone2_reg <= pti_pkg::TONE_RESET;
    end else begin
      if (wr_notone) begin
        notone_period_reg <= link_byte;
      end
      if (wr_tone1) begin
        tone1_reg <= {hi_byte_reg, link_byte};
      end
      if (wr_tone2) begin
        tone2_reg <= {hi_byte_reg, link_byte};
      end
    end
  end

  // all zero tone words put the encoders and then the summer to sleep
  assign enc1_save = (tone1_reg == pti_pkg::TONE_RESET);
  assign enc2_save = (tone2_reg == pti_pkg::TONE_RESET);
  assign sum_amp_save = enc1_save & enc2_save;

  // step length follows the band currently selected
  assign step_last = ctrl_reg[pti_pkg::CTRL_MID_BAND_BIT] ?
                     PRE_W'(STEP_MID_CYC - 1) :
                     PRE_W'(STEP_HIGH_CYC - 1);
  assign step_end = (pre_cnt_reg == step_last);
  // code zero means no period, so the timer never expires
  assign expire = (code_reg != '0) && step_end &&
                  (left_reg == pti_pkg::TMR_CODE_W'(1));

  // interval timer: a period is code steps of one band step each;
  // upper nibble of the byte is ignored rather than checked
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_reg <= pti_pkg::TIMER_RESET[pti_pkg::TMR_CODE_W-1:0];
      left_reg <= pti_pkg::TIMER_RESET[pti_pkg::TMR_CODE_W-1:0];
      pre_cnt_reg <= '0;
    end else if (gen_reset) begin
      code_reg <= pti_pkg::TIMER_RESET[pti_pkg::TMR_CODE_W-1:0];
      left_reg <= pti_pkg::TIMER_RESET[pti_pkg::TMR_CODE_W-1:0];
      pre_cnt_reg <= '0;
    end else if (wr_timer) begin
      code_reg <= link_byte[pti_pkg::TMR_CODE_W-1:0];
      left_reg <= link_byte[pti_pkg::TMR_CODE_W-1:0];
      pre_cnt_reg <= '0;
    end else if (code_reg != '0) begin
      if (step_end) begin
        pre_cnt_reg <= '0;
        if (expire) begin
          left_reg <= code_reg;
        end else begin
          left_reg <= left_reg - pti_pkg::TMR_CODE_W'(1);
        end
      end else begin
        pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
      end
    end
  end

  // flag causes; the decoder keeps pulsing while tones continue
  assign flag_set[pti_pkg::STAT_MEAS_BIT] = meas_done;
  assign flag_set[pti_pkg::STAT_NOTONE_BIT] = notone_expired;
  assign flag_set[pti_pkg::STAT_TIMER_BIT] = expire;
  assign flag_clr[pti_pkg::STAT_MEAS_BIT] = stat_read | gen_reset;
  assign flag_clr[pti_pkg::STAT_NOTONE_BIT] = stat_read | gen_reset |
                                              wr_notone;
  assign flag_clr[pti_pkg::STAT_TIMER_BIT] = stat_read | gen_reset |
                                             wr_timer;

  // sticky flags; an event in the clearing cycle wins over the clear
  for (genvar i = 0; i < pti_pkg::STAT_FLAGS; i++) begin : g_flag
    assign flag_next[i] = flag_set[i] | (flag_reg[i] & ~flag_clr[i]);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        flag_reg[i] <= pti_pkg::STATUS_RESET[i];
      end else begin
        flag_reg[i] <= flag_next[i];
      end
    end
  end

  // freeze the status byte for the reply before the flags clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_snap_reg <= pti_pkg::STATUS_RESET;
    end else if (stat_read) begin
      stat_snap_reg <= {5'h00, flag_reg};
    end
  end

  // one enable covers both decoder events, another the timer
  assign irq_en[pti_pkg::STAT_MEAS_BIT] =
    ctrl_next[pti_pkg::CTRL_DEC_IRQ_EN_BIT];
  assign irq_en[pti_pkg::STAT_NOTONE_BIT] =
    ctrl_next[pti_pkg::CTRL_DEC_IRQ_EN_BIT];
  assign irq_en[pti_pkg::STAT_TIMER_BIT] =
    ctrl_next[pti_pkg::CTRL_TMR_IRQ_EN_BIT];

  // registered request built from next state, so a status read
  // drops it in the same edge that clears the flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(flag_next & irq_en);
    end
  end
endmodule : pti_periodic_timer
`default_nettype wire

// ==== tb/pti_periodic_timer_chk.sv ====
// assertion checker watching the interval timer top module ports
`timescale 1ns/1ps
`default_nettype none
module pti_periodic_timer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus select, reply enable and interrupt
  input wire logic csn,
  input wire logic reply_data_oe_n,
  input wire logic irq_n,
  // decoder event hooks
  input wire logic meas_done,
  input wire logic notone_expired,
  // register contents and powersave levels
  input wire logic [7:0] ctrl_reg,
  input wire logic [7:0] notone_period_reg,
  input wire logic [15:0] tone1_reg,
  input wire logic [15:0] tone2_reg,
  input wire logic enc1_save,
  input wire logic enc2_save,
  input wire logic sum_amp_save
);
  // one clock domain here: all checks sleep while reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_amp_follows: assert property (
    sum_amp_save == (enc1_save && enc2_save))
    else $error("summing amp save does not follow both encoders");
  a_enc1_zero: assert property (
    enc1_save == (tone1_reg == 16'h0000))
    else $error("encoder 1 save does not match its tone word");
  a_enc2_zero: assert property (
    enc2_save == (tone2_reg == 16'h0000))
    else $error("encoder 2 save does not match its tone word");
  a_meas_irq: assert property (
    meas_done && ctrl_reg[5] |-> ##[1:3] !irq_n)
    else $error("measurement event raised no interrupt");
  a_notone_irq: assert property (
    notone_expired && ctrl_reg[5] |-> ##[1:3] !irq_n)
    else $error("tone absent event raised no interrupt");
  a_irq_masked: assert property (
    ctrl_reg[6:5] == 2'b00 |-> irq_n)
    else $error("interrupt active with every source disabled");
  // a flag only clears through a bus command, so a quiet bus keeps it
  a_irq_held: assert property (
    !irq_n && csn && $past(csn, 8) |=> !irq_n)
    else $error("interrupt dropped without a clearing command");
  a_oe_idle: assert property (
    csn && $past(csn, 2) |-> reply_data_oe_n)
    else $error("reply line driven outside a frame");
  a_gen_clear: assert property (
    $changed(ctrl_reg) && ctrl_reg == 8'h00 |-> tone1_reg == 16'h0000 &&
    tone2_reg == 16'h0000 && notone_period_reg == 8'h00)
    else $error("general reset left a register set");

  // main scenarios reached
  c_meas_irq: cover property (meas_done && ctrl_reg[5]);
  c_reply: cover property ($fell(reply_data_oe_n));
  c_gen_clear: cover property ($changed(ctrl_reg) && ctrl_reg == 8'h00);
endmodule : pti_periodic_timer_chk
`default_nettype wire

// ==== tb/pti_bus_host.sv ====
// microcontroller model driving the serial control bus
`timescale 1ns/1ps
`default_nettype none
module pti_bus_host (
  // lines towards the device
  output logic sclk,
  output logic csn,
  output logic cmd_data,
  // reply line from the device
  input wire logic reply_data_o,
  input wire logic reply_data_oe_n
);
  logic last_bit; // last level seen on the reply line
  // serial clock stands low between frames
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    cmd_data = 1'b1;
    last_bit = 1'b0;
  end
  // one frame of n bytes; rx holds what came back in the last slot
  task automatic frame(input logic [23:0] b, input int n,
                       output logic [7:0] rx);
    #200;
    csn = 1'b0;
    for (int k = 0; k < n; k++) begin
      // gap lets each byte cross into the system clock
      if (k > 0) begin
        #200;
      end
      for (int i = 7; i >= 0; i--) begin
        cmd_data = b[23 - 8 * k - (7 - i)]; // msb first
        #16;
        // undriven line floats: read the inverse of the last level;
        // the level is taken just before the edge, as a latch would
        rx[i] = reply_data_oe_n ? ~last_bit : reply_data_o;
        last_bit = rx[i];
        sclk = 1'b1;
        #16;
        sclk = 1'b0;
      end
    end
    csn = 1'b1;
    cmd_data = ~cmd_data; // released data line keeps no value
  endtask : frame
endmodule : pti_bus_host
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for interval timer, status flags and powersave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int S_HI = 20; // shortened high band step
  localparam int S_MID = 40; // shortened mid band step
  // design inputs driven by the bench
  logic clk, resetn, meas_done, notone_expired;
  // bus and design outputs
  wire logic sclk, csn, cmd_data, reply_data_o, reply_data_oe_n, irq_n;
  wire logic enc1_save, enc2_save, sum_amp_save;
  wire logic [7:0] ctrl_reg, notone_period_reg;
  wire logic [15:0] tone1_reg, tone2_reg;
  // counters and model state
  int err_total = 0, num_checks = 0, cyc = 0, t, st1, st2;
  logic [31:0] rs = 32'hD19E;
  logic [7:0] rx, ctrl_m, stat_m, nt_m;
  logic [15:0] t1_m, t2_m;

  pti_periodic_timer #(.STEP_HIGH_CYC(S_HI), .STEP_MID_CYC(S_MID),
    .PRE_W(22)) pti_periodic_timer_inst (.clk(clk), .resetn(resetn),
    .sclk(sclk), .csn(csn), .cmd_data(cmd_data),
    .reply_data_o(reply_data_o), .reply_data_oe_n(reply_data_oe_n),
    .irq_n(irq_n), .meas_done(meas_done), .notone_expired(notone_expired),
    .ctrl_reg(ctrl_reg), .notone_period_reg(notone_period_reg),
    .tone1_reg(tone1_reg), .tone2_reg(tone2_reg), .enc1_save(enc1_save),
    .enc2_save(enc2_save), .sum_amp_save(sum_amp_save));
  pti_bus_host pti_bus_host_inst (.sclk(sclk), .csn(csn),
    .cmd_data(cmd_data), .reply_data_o(reply_data_o),
    .reply_data_oe_n(reply_data_oe_n));

  // system clock and free cycle stamp
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // xorshift source for stimulus
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  // interrupt level the model predicts
  function automatic logic irq_exp();
    return ~|(stat_m[2:0] & {ctrl_m[6], ctrl_m[5], ctrl_m[5]});
  endfunction : irq_exp
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_cyc(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, lo);
    end
  endtask : cmp_cyc
  // frame plus settling time for the crossing
  task automatic bus(input logic [23:0] b, input int n);
    pti_bus_host_inst.frame(b, n, rx);
    repeat (10) @(posedge clk);
  endtask : bus
  task automatic check_regs();
    cmp_val(ctrl_reg, ctrl_m);
    cmp_val(notone_period_reg, nt_m);
    cmp_val(tone1_reg, t1_m);
    cmp_val(tone2_reg, t2_m);
    cmp_val({enc1_save, enc2_save, sum_amp_save},
      {t1_m == 0, t2_m == 0, t1_m == 0 && t2_m == 0});
    cmp_val(irq_n, irq_exp());
  endtask : check_regs
  task automatic read_status();
    pti_bus_host_inst.frame({pti_pkg::CMD_READ_STATUS, 16'h0}, 2, rx);
    cmp_val(rx, stat_m);
    stat_m = 8'h00;
    repeat (10) @(posedge clk);
    cmp_val(irq_n, 1'b1);
  endtask : read_status
  // bounded wait for the interrupt, stamped with the cycle count
  task automatic wait_irq(output int st);
    for (int k = 0; k < 2000; k++) begin
      @(negedge clk);
      if (irq_n === 1'b0) break;
    end
    st = cyc;
  endtask : wait_irq
  task automatic gen_reset();
    bus({pti_pkg::CMD_GEN_RESET, 16'h0}, 1);
    {ctrl_m, stat_m, nt_m, t1_m, t2_m} = '0;
    check_regs();
  endtask : gen_reset
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // watchdog: the whole run needs well under this span
  initial begin
    #400us;
    err_total++;
    stop_test();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    meas_done = 1'b0;
    notone_expired = 1'b0;
    {ctrl_m, stat_m, nt_m, t1_m, t2_m} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check_regs();
    gen_reset();
    $display("test reset done");
    // registers and powersave; control never written as zero
    for (int k = 0; k < 4; k++) begin
      t = xs();
      ctrl_m = {1'b0, t[1:0], 5'h08};
      t1_m = (k == 0) ? 16'h2000 : (t[5] ? 16'h0000 : t[31:16]);
      t2_m = t[6] ? 16'h0000 : t[15:0];
      nt_m = {4'h0, t[11:8]};
      bus({pti_pkg::CMD_CTRL_WR, ctrl_m, 8'h00}, 2);
      bus({pti_pkg::CMD_TONE1_WR, t1_m}, 3);
      bus({pti_pkg::CMD_TONE2_WR, t2_m}, 3);
      bus({pti_pkg::CMD_NOTONE_WR, nt_m, 8'h00}, 2);
      check_regs();
    end
    gen_reset();
    $display("test registers done");
    // decoder events, masks and status reads
    for (int k = 0; k < 6; k++) begin
      t = xs();
      ctrl_m = {1'b0, t[1:0], 5'h08};
      bus({pti_pkg::CMD_CTRL_WR, ctrl_m, 8'h00}, 2);
      meas_done <= t[2];
      notone_expired <= t[3];
      @(posedge clk);
      meas_done <= 1'b0;
      notone_expired <= 1'b0;
      stat_m = {6'h00, t[3], t[2]};
      repeat (5) @(posedge clk);
      cmp_val(irq_n, irq_exp());
      read_status();
    end
    $display("test events done");
    // high band timer: period, repeat, hold, clear by new write
    ctrl_m = 8'h48;
    bus({pti_pkg::CMD_CTRL_WR, ctrl_m, 8'h00}, 2);
    pti_bus_host_inst.frame({pti_pkg::CMD_TIMER_WR, 8'h0F, 8'h00}, 2,
      rx);
    t = cyc;
    wait_irq(st1);
    cmp_cyc(st1 - t, 15 * S_HI - 2, 15 * S_HI + 5);
    stat_m = 8'h04;
    read_status();
    wait_irq(st2);
    cmp_cyc(st2 - st1, 15 * S_HI, 15 * S_HI);
    repeat (15 * S_HI + 20) @(posedge clk);
    cmp_val(irq_n, 1'b0);
    stat_m = 8'h00;
    bus({pti_pkg::CMD_TIMER_WR, 8'h00, 8'h00}, 2);
    cmp_val(irq_n, 1'b1);
    read_status();
    repeat (500) @(posedge clk);
    cmp_val(irq_n, 1'b1);
    $display("test high band timer done");
    // mid band doubles the step
    ctrl_m = 8'h49;
    bus({pti_pkg::CMD_CTRL_WR, ctrl_m, 8'h00}, 2);
    pti_bus_host_inst.frame({pti_pkg::CMD_TIMER_WR, 8'h05, 8'h00}, 2,
      rx);
    t = cyc;
    wait_irq(st1);
    cmp_cyc(st1 - t, 5 * S_MID - 2, 5 * S_MID + 5);
    gen_reset();
    // a cleared timer must stay silent for longer than its old period
    repeat (8 * S_MID) @(posedge clk);
    read_status();
    $display("test mid band timer done");
    stop_test();
  end
endmodule : tb_top

bind pti_periodic_timer pti_periodic_timer_chk pti_periodic_timer_chk_inst (
  .clk(clk), .resetn(resetn), .csn(csn), .reply_data_oe_n(reply_data_oe_n),
  .irq_n(irq_n), .meas_done(meas_done), .notone_expired(notone_expired),
  .ctrl_reg(ctrl_reg), .notone_period_reg(notone_period_reg),
  .tone1_reg(tone1_reg), .tone2_reg(tone2_reg), .enc1_save(enc1_save),
  .enc2_save(enc2_save), .sum_amp_save(sum_amp_save));
`default_nettype wire
